// ---- design/smcg_pkg.sv ----
// Notes on behaviour
// - sleep only when arm bit set
// - select field picks one of four modes
// - interrupt wake halts four extra cycles
// - register file and RAM keep contents
// - reset during sleep restarts at vector
// - arm bit5, select bits4:3, bit2 zero
// - idle stops only cpu and flash clocks
// - idle wakes on external and internal irqs
// - idle or noise mode starts conversion
// - noise mode stops io, cpu, flash clocks
// - noise mode limited wake sources
// - power-down stops oscillator, few wake sources
// - standby keeps oscillator only on crystal source, wakes in six
// - gating bit freezes peripheral and registers
// - ungating restores frozen peripheral state
// - gating matters in active and idle
// - gate bits 3..0, bits 7:4 zero
// - gated converter denies comparator mux
package smcg_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [3:0] ADDR_SLEEP_CTRL = 4'h0;
   localparam logic [3:0] ADDR_CLK_GATE   = 4'h1;
   localparam logic [3:0] ADDR_STATUS     = 4'h2;
   localparam int         BIT_ARM         = 5;
   localparam int         BIT_SEL_HI      = 4;
   localparam int         BIT_SEL_LO      = 3;
   localparam int         BIT_G_TIM1      = 3;
   localparam int         BIT_G_TIM0      = 2;
   localparam int         BIT_G_SER       = 1;
   localparam int         BIT_G_CONV      = 0;
   localparam logic [7:0] CTRL_RESET      = 8'h00;
   localparam logic [7:0] CTRL_WMASK      = 8'h38;
   localparam logic [7:0] GATE_RESET      = 8'h00;
   localparam logic [7:0] GATE_WMASK      = 8'h0f;
   // ----------------------------------------
   // modes and timing
   // ----------------------------------------
   localparam logic [1:0] MODE_IDLE    = 2'h0;
   localparam logic [1:0] MODE_NOISE   = 2'h1;
   localparam logic [1:0] MODE_PDOWN   = 2'h2;
   localparam logic [1:0] MODE_STANDBY = 2'h3;
   localparam logic [3:0] EXTRA_HALT   = 4'h4;
   localparam logic [3:0] STANDBY_WAKE = 4'h6;
   localparam logic [3:0] ZERO4        = 4'h0;
   localparam logic [3:0] ONE4         = 4'h1;
   typedef enum logic [3:0] {
      ST_RUN   = 4'b0001,
      ST_SLEEP = 4'b0010,
      ST_START = 4'b0100,
      ST_HALT  = 4'b1000
   } smcg_state_e;
endpackage

// ---- design/smcg_sleep_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module smcg_sleep_ctrl
   import smcg_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   output logic      [7:0] regRdata,
   input  wire logic       sleepInstr,
   input  wire logic       oscStableIn,
   input  wire logic [3:0] startupCycles,
   input  wire logic       crystalSource,
   input  wire logic       converterEnabled,
   input  wire logic       wakeExtIrq,
   input  wire logic       wakeExtLevel0,
   input  wire logic       wakePinChange,
   input  wire logic       wakeTimerIrq,
   input  wire logic       wakeComparatorIrq,
   input  wire logic       wakeOtherIoIrq,
   input  wire logic       wakeConvDone,
   input  wire logic       wakeStoreReady,
   input  wire logic       wakeWatchdogIrq,
   output logic            cpuClkEn,
   output logic            flashClkEn,
   output logic            ioClkEn,
   output logic            convClkEn,
   output logic            oscEn,
   output logic            timer1ClkEn,
   output logic            timer0ClkEn,
   output logic            serialClkEn,
   output logic            convGateClkEn,
   output logic            periphRegBlock,
   output logic            comparatorMuxAllow,
   output logic            convStart,
   output logic            irqResume,
   output logic            sleepDone
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0]  ctrlReg;
   logic [7:0]  gateReg;
   logic [3:0]  cntReg;
   logic [1:0]  modeReg;
   smcg_state_e stateReg;
   logic        wakeAny;
   logic        enterSleep;

   // control register; reset lands here since reset_n restarts at vector
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrlReg <= CTRL_RESET;
      end else if (regWrite && regAddr == ADDR_SLEEP_CTRL) begin
         ctrlReg <= regWdata & CTRL_WMASK;
      end
   end

   // gating register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         gateReg <= GATE_RESET;
      end else if (regWrite && regAddr == ADDR_CLK_GATE) begin
         gateReg <= regWdata & GATE_WMASK;
      end
   end

   // read port, one cycle latency; unmapped reads zero
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         case (regAddr)
            ADDR_SLEEP_CTRL: regRdata <= ctrlReg;
            ADDR_CLK_GATE:   regRdata <= gateReg;
            ADDR_STATUS:     regRdata <= {4'h0, stateReg};
            default:         regRdata <= 8'h00;
         endcase
      end else begin
         regRdata <= 8'h00;
      end
   end

   // ----------------------------------------
   // wake filtering per mode
   // ----------------------------------------
   // armed sleep only; unarmed instruction falls through as a no-op
   assign enterSleep = sleepInstr && ctrlReg[BIT_ARM];
   always_comb begin
      case (modeReg)
         MODE_IDLE: wakeAny = wakeExtIrq | wakeExtLevel0 | wakePinChange
                              | wakeTimerIrq | wakeComparatorIrq | wakeOtherIoIrq
                              | wakeConvDone | wakeStoreReady
                              | wakeWatchdogIrq;
         MODE_NOISE: wakeAny = wakeConvDone | wakeStoreReady | wakeExtLevel0
                               | wakePinChange | wakeWatchdogIrq;
         default: wakeAny = wakeExtLevel0 | wakePinChange
                            | wakeWatchdogIrq;
      endcase
   end

   // ----------------------------------------
   // sleep sequencer
   // ----------------------------------------
   // cpu state and RAM are untouched: only clocks stop, nothing is cleared
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stateReg <= ST_RUN;
         modeReg  <= MODE_IDLE;
         cntReg   <= ZERO4;
      end else begin
         case (stateReg)
            ST_RUN: begin
               if (enterSleep) begin
                  modeReg  <= ctrlReg[BIT_SEL_HI:BIT_SEL_LO];
                  stateReg <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               if (wakeAny) begin
                  stateReg <= ST_START;
                  // standby oscillator still runs, so a fixed short wake
                  if (modeReg == MODE_STANDBY && crystalSource) begin
                     cntReg <= STANDBY_WAKE - ONE4;
                  end else if (modeReg == MODE_PDOWN || modeReg == MODE_STANDBY) begin
                     cntReg <= startupCycles;
                  end else begin
                     cntReg <= ZERO4;
                  end
               end
            end
            ST_START: begin
               // count down startup cycles, then hold until oscillator stable
               if (cntReg != ZERO4) begin
                  cntReg <= cntReg - ONE4;
               end else if (oscStableIn) begin
                  cntReg   <= EXTRA_HALT - ONE4;
                  stateReg <= ST_HALT;
               end
            end
            ST_HALT: begin
               if (cntReg != ZERO4) begin
                  cntReg <= cntReg - ONE4;
               end else begin
                  stateReg <= ST_RUN;
               end
            end
            default: stateReg <= ST_RUN;
         endcase
      end
   end

   // ----------------------------------------
   // clock enables per domain
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cpuClkEn   <= 1'b1;
         flashClkEn <= 1'b1;
         ioClkEn    <= 1'b1;
         convClkEn  <= 1'b1;
         oscEn      <= 1'b1;
      end else begin
         cpuClkEn   <= (stateReg == ST_RUN) && !enterSleep;
         flashClkEn <= (stateReg == ST_RUN) && !enterSleep;
         if (stateReg == ST_SLEEP || (stateReg == ST_RUN && enterSleep)) begin
            // mode source: latched mode while asleep, select field on entry
            case (stateReg == ST_SLEEP ? modeReg : ctrlReg[BIT_SEL_HI:BIT_SEL_LO])
               MODE_IDLE: begin
                  ioClkEn   <= 1'b1;
                  convClkEn <= 1'b1;
                  oscEn     <= 1'b1;
               end
               MODE_NOISE: begin
                  ioClkEn   <= 1'b0;
                  convClkEn <= 1'b1;
                  oscEn     <= 1'b1;
               end
               MODE_STANDBY: begin
                  ioClkEn   <= 1'b0;
                  convClkEn <= 1'b0;
                  oscEn     <= crystalSource;
               end
               default: begin
                  ioClkEn   <= 1'b0;
                  convClkEn <= 1'b0;
                  oscEn     <= 1'b0;
               end
            endcase
         end else begin
            ioClkEn   <= 1'b1;
            convClkEn <= 1'b1;
            oscEn     <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // per-peripheral gating
   // ----------------------------------------
   // gating clears enables and blocks registers; peripheral flops hold, so ungating resumes
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         timer1ClkEn        <= 1'b1;
         timer0ClkEn        <= 1'b1;
         serialClkEn        <= 1'b1;
         convGateClkEn      <= 1'b1;
         periphRegBlock     <= 1'b0;
         comparatorMuxAllow <= 1'b1;
      end else begin
         // deeper modes stop io clock anyway, so gating only shows in active/idle
         timer1ClkEn        <= !gateReg[BIT_G_TIM1];
         timer0ClkEn        <= !gateReg[BIT_G_TIM0];
         serialClkEn        <= !gateReg[BIT_G_SER];
         convGateClkEn      <= !gateReg[BIT_G_CONV];
         periphRegBlock     <= |gateReg[3:0];
         comparatorMuxAllow <= !gateReg[BIT_G_CONV];
      end
   end

   // ----------------------------------------
   // event pulses
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         convStart <= 1'b0;
         irqResume <= 1'b0;
         sleepDone <= 1'b0;
      end else begin
         // auto conversion on idle or noise entry with converter live
         convStart <= enterSleep && converterEnabled && !gateReg[BIT_G_CONV]
                      && !ctrlReg[BIT_SEL_HI];
         irqResume <= (stateReg == ST_HALT) && (cntReg == ZERO4);
         sleepDone <= sleepInstr && !ctrlReg[BIT_ARM] && (stateReg == ST_RUN);
      end
   end
endmodule
`default_nettype wire

// ---- verif/smcg_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module smcg_monitor
   import smcg_pkg::*;
(
   input wire logic       clk, reset_n, regWrite, regRead, sleepInstr,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata, regRdata,
   input wire logic       cpuClkEn, flashClkEn, ioClkEn, convClkEn, oscEn,
   input wire logic       timer1ClkEn, timer0ClkEn, serialClkEn, convGateClkEn,
   input wire logic       periphRegBlock, comparatorMuxAllow, convStart, irqResume
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ----------------------------------------
   // shadow of the arm bit
   // ----------------------------------------
   // kept here so an armed sleep can be told apart from a refused one
   logic armReg;
   always_ff @(posedge clk) begin
      if (!reset_n)
         armReg <= 1'b0;
      else if (regWrite && regAddr == ADDR_SLEEP_CTRL)
         armReg <= regWdata[BIT_ARM];
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_armed; sleepInstr && cpuClkEn && armReg |=> !cpuClkEn; endproperty
   a_armed: assert property (p_armed) else $error("armed sleep left cpu clock on");
   property p_unarmed; sleepInstr && cpuClkEn && !armReg |=> cpuClkEn [*2]; endproperty
   a_unarmed: assert property (p_unarmed) else $error("unarmed sleep gated cpu");
   property p_halt; irqResume |-> !cpuClkEn && !$past(cpuClkEn, 4) ##1 cpuClkEn; endproperty
   a_halt: assert property (p_halt) else $error("resume without halt cycles");
   property p_flash; cpuClkEn == flashClkEn; endproperty
   a_flash: assert property (p_flash) else $error("cpu and flash clocks differ");
   // io clock stops only with the cpu stopped, and the converter clock may then run only while the oscillator runs
   property p_io; !ioClkEn |-> !cpuClkEn && (!convClkEn || oscEn); endproperty
   a_io: assert property (p_io) else $error("io clock off with cpu running");
   property p_osc; !oscEn |-> !convClkEn && !ioClkEn && !cpuClkEn; endproperty
   a_osc: assert property (p_osc) else $error("clock running with oscillator off");
   property p_block;
      periphRegBlock == !(timer1ClkEn && timer0ClkEn && serialClkEn && convGateClkEn);
   endproperty
   a_block: assert property (p_block) else $error("register block disagrees with gating");
   property p_mux; comparatorMuxAllow == convGateClkEn; endproperty
   a_mux: assert property (p_mux) else $error("comparator mux allowed while gated");
   property p_conv; convStart |-> ($past(sleepInstr) || $past(sleepInstr, 2)); endproperty
   a_conv: assert property (p_conv) else $error("conversion start without sleep");
   property p_rdidle; regRdata != 8'h00 |-> $past(regRead); endproperty
   a_rdidle: assert property (p_rdidle) else $error("read data outside read slot");
   property p_rdctl;
      $past(regRead) && $past(regAddr) == ADDR_SLEEP_CTRL |-> (regRdata & ~CTRL_WMASK) == 8'h00;
   endproperty
   a_rdctl: assert property (p_rdctl) else $error("reserved control bits read nonzero");
   c_resume: cover property (irqResume);
   c_conv: cover property (convStart);
   c_refused: cover property (sleepInstr && cpuClkEn && !armReg);
endmodule
`default_nettype wire

// ---- verif/smcg_sleep_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module smcg_sleep_ctrl_tb;
   import smcg_pkg::*;
   logic       clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, sleepInstr = 1'b0;
   logic [3:0] regAddr = 4'h0, startupCycles = 4'h2;
   logic [7:0] regWdata = 8'h00, regRdata;
   logic [8:0] wk = 9'h000;
   logic       crystalSource = 1'b1, converterEnabled = 1'b1, sawConv = 1'b0;
   logic       cpuClkEn, flashClkEn, ioClkEn, convClkEn, oscEn, convStart, irqResume;
   logic       timer1ClkEn, timer0ClkEn, serialClkEn, convGateClkEn, periphRegBlock;
   logic       comparatorMuxAllow, sleepDone;
   int         miscompares = 0, tests_run = 0, cyc = 0;
   smcg_sleep_ctrl u_dut (.clk, .reset_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
      .sleepInstr, .oscStableIn(1'b1), .startupCycles, .crystalSource, .converterEnabled,
      .wakeExtIrq(wk[8]), .wakeExtLevel0(wk[7]), .wakePinChange(wk[6]), .wakeTimerIrq(wk[5]),
      .wakeComparatorIrq(wk[4]), .wakeOtherIoIrq(wk[3]), .wakeConvDone(wk[2]),
      .wakeStoreReady(wk[1]), .wakeWatchdogIrq(wk[0]), .cpuClkEn, .flashClkEn, .ioClkEn,
      .convClkEn, .oscEn, .timer1ClkEn, .timer0ClkEn, .serialClkEn, .convGateClkEn,
      .periphRegBlock, .comparatorMuxAllow, .convStart, .irqResume, .sleepDone);
   // ----------------------------------------
   // clock, timeout and helpers
   // ----------------------------------------
   always #2.5 clk = ~clk;
   // whole run needs about three hundred cycles
   always @(posedge clk) begin
      cyc++;
      if (convStart)
         sawConv <= 1'b1;
      if (cyc == 5000) begin
         miscompares++;
         final_report();
      end
   end
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(logic [3:0] a, logic [7:0] e, string nm);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk(nm, e, regRdata);
   endtask
   task automatic sleep_go(logic [1:0] m);
      wr(ADDR_SLEEP_CTRL, {2'b00, 1'b1, m, 3'b000});
      @(posedge clk);
      sleepInstr <= 1'b1;
      sawConv = 1'b0;
      @(posedge clk);
      sleepInstr <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   // raise one wake source, count cycles to resume, then disarm
   task automatic wake_by(int b, output int n);
      @(posedge clk);
      wk[b] <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         #1;
      end while (!irqResume && n < 60);
      @(posedge clk);
      wk <= 9'h000;
      wr(ADDR_SLEEP_CTRL, 8'h00);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      rd(ADDR_SLEEP_CTRL, CTRL_RESET, "ctrl reset");
      rd(ADDR_CLK_GATE, GATE_RESET, "gate reset");
      wr(ADDR_SLEEP_CTRL, 8'hff);
      rd(ADDR_SLEEP_CTRL, CTRL_WMASK, "ctrl mask");
      wr(4'h9, 8'hff);
      rd(4'h9, 8'h00, "unmapped");
      wr(ADDR_SLEEP_CTRL, 8'h00);
      converterEnabled <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_CLK_GATE, 8'hf0 | (8'h01 << i));
         rd(ADDR_CLK_GATE, 8'h01 << i, "gate bits");
         chk("gate enables", {4'h0, ~(4'h1 << i)},
             {4'h0, timer1ClkEn, timer0ClkEn, serialClkEn, convGateClkEn});
         chk("comparator mux", {7'h0, i != 0}, {7'h0, comparatorMuxAllow});
         chk("reg block", 8'h01, {7'h0, periphRegBlock});
      end
      wr(ADDR_CLK_GATE, 8'h00);
      rd(ADDR_CLK_GATE, 8'h00, "gate clear");
      chk("reg block clear", 8'h00, {7'h0, periphRegBlock});
      converterEnabled <= 1'b1;
      $display("test regs done");
   endtask
   task automatic t_unarmed();
      @(posedge clk);
      sleepInstr <= 1'b1;
      @(posedge clk);
      sleepInstr <= 1'b0;
      #1 chk("unarmed done", 8'h01, {7'h0, sleepDone});
      repeat (2) @(posedge clk);
      #1 chk("unarmed cpu clock", 8'h01, {7'h0, cpuClkEn});
      $display("test unarmed done");
   endtask
   task automatic t_modes();
      int n;
      for (int m = 0; m < 4; m++) begin
         sleep_go(m[1:0]);
         chk("domains", {3'h0, m == 0, m < 2, m != 2, 2'b00},
             {3'h0, ioClkEn, convClkEn, oscEn, cpuClkEn, flashClkEn});
         wake_by(7, n);
         chk("wake latency", 8'h01, {7'h0, n >= (m == 3 ? 10 : m == 2 ? 6 : 4)});
         chk("conversion start", {7'h0, m < 2}, {7'h0, sawConv});
      end
      $display("test modes done");
   endtask
   task automatic t_sources();
      int n;
      for (int b = 0; b < 9; b++) begin
         sleep_go(MODE_IDLE);
         wake_by(b, n);
         chk("idle wake", 8'h01, {7'h0, n < 60});
      end
      $display("test sources done");
   endtask
   // a timer irq must not end noise reduction or power-down
   task automatic t_filter();
      int n;
      for (int m = 1; m < 3; m++) begin
         sleep_go(m[1:0]);
         @(posedge clk);
         wk[5] <= 1'b1;
         repeat (10) @(posedge clk);
         #1 chk("filtered wake", 8'h00, {7'h0, cpuClkEn});
         wake_by(m == 1 ? 2 : 6, n);
         chk("allowed wake", 8'h01, {7'h0, n < 60});
      end
      $display("test filter done");
   endtask
   task automatic t_reset();
      sleep_go(MODE_PDOWN);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      #1 chk("cpu clock after reset", 8'h01, {7'h0, cpuClkEn});
      rd(ADDR_STATUS, 8'h01, "status after reset");
      rd(ADDR_SLEEP_CTRL, 8'h00, "ctrl after reset");
      $display("test reset done");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      t_regs();
      t_unarmed();
      t_modes();
      t_sources();
      t_filter();
      t_reset();
      final_report();
   end
endmodule
bind smcg_sleep_ctrl smcg_monitor u_mon (.clk, .reset_n, .regWrite, .regRead, .sleepInstr,
   .regAddr, .regWdata, .regRdata, .cpuClkEn, .flashClkEn, .ioClkEn, .convClkEn, .oscEn,
   .timer1ClkEn, .timer0ClkEn, .serialClkEn, .convGateClkEn, .periphRegBlock,
   .comparatorMuxAllow, .convStart, .irqResume);
`default_nettype wire
